// file: src/sfwp_pkg.sv
// constants and types of the serial flash register write-protect block
package sfwp_pkg;

    // command opcodes seen on the serial input
    localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
    localparam logic [7:0] OP_WRITE_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_READ_CONFIG = 8'h15;
    localparam logic [7:0] OP_WRITE_REGISTERS = 8'h01;

    // status register field positions
    localparam int SR_BUSY = 0;
    localparam int SR_LATCH = 1;
    localparam int SR_LEVEL_LO = 2;
    localparam int SR_LEVEL_HI = 5;
    localparam int SR_QUAD = 6;
    localparam int SR_LOCK = 7;

    // configuration register field position
    localparam int CR_ORIGIN = 3;

    // reset values of the stored bits
    localparam logic [3:0] LEVEL_RESET = 4'h0;
    localparam logic QUAD_RESET = 1'b0;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic ORIGIN_RESET = 1'b0;

    // frame lengths in serial clock edges
    localparam logic [4:0] BITS_OPCODE = 5'h08;
    localparam logic [4:0] BITS_WRITE_ONE = 5'h10;
    localparam logic [4:0] BITS_WRITE_TWO = 5'h18;
    localparam logic [4:0] BITS_MAX = 5'h1F;

    // self-timed register write cycle
    localparam int CLK_PERIOD_NS = 100;
    localparam int WRITE_TIME_NS = 1000000;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_OPCODE = 2'b00,
        ST_ARGS = 2'b01,
        ST_READOUT = 2'b10
    } sfwp_cmd_state_t;

endpackage : sfwp_pkg

// file: src/sfwp_sync.sv
// two-flop synchroniser for pins from outside the clock domain
module sfwp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1;

    if (WIDTH < 1) begin : gBadWidth
        $error("sfwp_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end

endmodule : sfwp_sync

// file: src/sfwp_core.sv
// register write and write-protect logic of a serial flash
// What this block does
// [R1] One-time orientation bit at configuration bit3: 0 top area, 1 bottom area.
// [R2] Orientation bit changes only through the register-write command.
// [R3] Configuration read accepted any time, even during a busy cycle.
// [R4] Configuration read drives the byte on the serial output; upper lines ignored.
// [R5] Host should poll the busy flag before new commands while busy.
// [R6] Register write updates level bits, quad enable and lock bit; a two-byte write also the configuration.
// [R7] Host sets the write latch before a register write.
// [R8] Shifted data never alters the write latch or busy flag directly.
// [R9] Register write refused in hardware-locked mode.
// [R10] Host frames a register write as opcode, data bytes, chip select high.
// [R11] Register write rejected unless chip select rises after 8 or 16 data bits.
// [R12] Self-timed write cycle starts at the chip select rise of a valid write.
// [R13] Busy reads 1 during the cycle; at its end busy and latch clear.
// [R14] Lock bit 0: latch settable and protect bits writable whatever the pin.
// [R15] Lock bit 1 and pin high: protect bits still writable after latch set.
// [R16] Lock bit 1, pin low and quad off: every register write rejected.
// [R17] Hardware lock whenever lock bit 1, pin low and quad off, in either order.
// [R18] Hardware lock lasts until the pin goes high; tied high means software only.
// [R19] Program and erase into the protected area are refused in both modes.
// [R20] Host keeps the write-guard pin high until the write cycle ends.
// [R21] Latch set by its command, cleared by program/erase end or protected refusal.
// [R22] Level bits stored, default 0 meaning nothing protected.
// [R23] Two-byte write: first byte status, second configuration, MSB first.
// [R24] Orientation bit once 1 stays 1.
module sfwp_core #(
    parameter int WRITE_CYCLES = sfwp_pkg::WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic serialIn,
    input wire logic writeGuardPinN,
    input wire logic arrayBusy,
    input wire logic eraseProgramReq,
    input wire logic eraseProgramProtected,
    input wire logic eraseProgramDone,
    output logic serialOut,
    output logic serialOutEn,
    output logic eraseProgramGo,
    output logic eraseProgramRefused,
    output logic [3:0] protectLevel,
    output logic areaOriginSelect,
    output logic quadIoEnable,
    output logic registerLockBit,
    output logic writeLatch,
    output logic busyFlag,
    output logic hardLockMode
);

    localparam int CW = $clog2(WRITE_CYCLES + 1);

    if (WRITE_CYCLES < 2) begin : gBadCycles
        $error("sfwp_core: WRITE_CYCLES must be at least 2");
    end

    // pins into the clock domain
    logic [3:0] pinSync;
    logic csS, sclkS, siS, wpS;
    logic csPrev, sclkPrev;

    sfwp_sync #(
        .WIDTH(4),
        .RESET_VAL(4'h9)
    ) uSync (
        .clk(clk),
        .rstn(rstn),
        .d({chipSelectN, serialClock, serialIn, writeGuardPinN}),
        .q(pinSync)
    );

    assign csS = pinSync[3];
    assign sclkS = pinSync[2];
    assign siS = pinSync[1];
    assign wpS = pinSync[0];

    wire csFall = csPrev && !csS;
    wire csRise = !csPrev && csS;
    wire sclkRise = !sclkPrev && sclkS && !csS;
    wire sclkFall = sclkPrev && !sclkS && !csS;

    // frame state
    sfwp_pkg::sfwp_cmd_state_t state, next_state;
    logic [4:0] bitCnt;
    logic [15:0] rxShift;
    logic [7:0] cmdOp;
    logic [7:0] txShift;
    logic [2:0] txCnt;

    // write cycle state
    logic wrBusy;
    logic [CW-1:0] wrCnt;
    logic [7:0] pendStatus;
    logic [7:0] pendConfig;
    logic pendTwo;

    wire [7:0] opByte = {rxShift[6:0], siS};
    wire opcodeDone = sclkRise && state == sfwp_pkg::ST_OPCODE && bitCnt == sfwp_pkg::BITS_OPCODE - 5'h01;
    wire opIsRead = opByte == sfwp_pkg::OP_READ_STATUS || opByte == sfwp_pkg::OP_READ_CONFIG;
    wire busyNow = wrBusy || arrayBusy;

    // quad mode disables the guard pin, so hardware lock needs quad off
    wire hardLockNow = registerLockBit && !wpS && !quadIoEnable; // [R17] [R18]

    wire [7:0] statusByte = {registerLockBit, quadIoEnable, protectLevel, writeLatch, busyNow};
    wire [7:0] configByte = 8'(areaOriginSelect) << sfwp_pkg::CR_ORIGIN; // [R1]
    wire [7:0] liveOp = opcodeDone ? opByte : cmdOp;
    wire [7:0] readByte = liveOp == sfwp_pkg::OP_READ_CONFIG ? configByte : statusByte; // [R4]

    wire argsEnd = csRise && state == sfwp_pkg::ST_ARGS;
    wire lenValid = bitCnt == sfwp_pkg::BITS_WRITE_ONE || bitCnt == sfwp_pkg::BITS_WRITE_TWO; // [R11]
    wire wrStart = argsEnd && cmdOp == sfwp_pkg::OP_WRITE_REGISTERS && lenValid && writeLatch
        && !busyNow && !hardLockNow; // [R9] [R12] [R14] [R15] [R16]
    wire wrDone = wrBusy && wrCnt == CW'(1);
    wire latchSet = argsEnd && cmdOp == sfwp_pkg::OP_WRITE_LATCH_SET && bitCnt == sfwp_pkg::BITS_OPCODE
        && !busyNow; // [R21]
    wire latchClrCmd = argsEnd && cmdOp == sfwp_pkg::OP_WRITE_LATCH_CLR && bitCnt == sfwp_pkg::BITS_OPCODE
        && !busyNow;
    wire peGrant = eraseProgramReq && writeLatch && !busyNow && !eraseProgramProtected; // [R19]
    wire peRefuse = eraseProgramReq && eraseProgramProtected; // [R19] [R21]
    wire latchClr = wrDone || eraseProgramDone || peRefuse || latchClrCmd; // [R13] [R21]
    wire next_writeLatch = latchSet ? 1'b1 : (latchClr ? 1'b0 : writeLatch);

    // frame sequencing; reads go through even while busy
    always_comb begin
        next_state = state;
        unique case (state)
            sfwp_pkg::ST_OPCODE: begin
                if (opcodeDone) begin
                    next_state = opIsRead ? sfwp_pkg::ST_READOUT : sfwp_pkg::ST_ARGS; // [R3]
                end
            end
            sfwp_pkg::ST_ARGS: begin
                next_state = sfwp_pkg::ST_ARGS;
            end
            sfwp_pkg::ST_READOUT: begin
                next_state = sfwp_pkg::ST_READOUT;
            end
            default: begin
                next_state = sfwp_pkg::ST_OPCODE;
            end
        endcase
        if (csFall || csS) begin
            next_state = sfwp_pkg::ST_OPCODE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            csPrev <= 1'b1;
            sclkPrev <= 1'b0;
            state <= sfwp_pkg::ST_OPCODE;
        end else begin
            csPrev <= csS;
            sclkPrev <= sclkS;
            state <= next_state;
        end
    end

    // input shifter, MSB first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bitCnt <= 5'h00;
            rxShift <= 16'h0000;
            cmdOp <= 8'h00;
        end else if (csFall) begin
            bitCnt <= 5'h00;
        end else if (sclkRise) begin
            rxShift <= {rxShift[14:0], siS}; // [R23]
            bitCnt <= bitCnt == sfwp_pkg::BITS_MAX ? bitCnt : bitCnt + 5'h01;
            if (opcodeDone) begin
                cmdOp <= opByte;
            end
        end
    end

    // output shifter; byte repeats while chip select stays low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txShift <= 8'h00;
            txCnt <= 3'h0;
            serialOut <= 1'b0;
            serialOutEn <= 1'b0;
        end else begin
            serialOutEn <= !csS && state == sfwp_pkg::ST_READOUT; // [R4]
            if (opcodeDone && opIsRead) begin
                txShift <= readByte;
                txCnt <= 3'h0;
            end else if (sclkFall && state == sfwp_pkg::ST_READOUT) begin
                serialOut <= txShift[7]; // [R4]
                txShift <= txCnt == 3'h7 ? readByte : {txShift[6:0], 1'b0};
                txCnt <= txCnt + 3'h1;
            end
        end
    end

    // self-timed register write cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrBusy <= 1'b0;
            wrCnt <= '0;
            pendStatus <= 8'h00;
            pendConfig <= 8'h00;
            pendTwo <= 1'b0;
        end else if (wrStart) begin
            wrBusy <= 1'b1; // [R12] [R13]
            wrCnt <= CW'(WRITE_CYCLES);
            pendTwo <= bitCnt == sfwp_pkg::BITS_WRITE_TWO;
            pendStatus <= bitCnt == sfwp_pkg::BITS_WRITE_TWO ? rxShift[15:8] : rxShift[7:0]; // [R23]
            pendConfig <= rxShift[7:0];
        end else if (wrBusy) begin
            wrCnt <= wrCnt - CW'(1);
            if (wrDone) begin
                wrBusy <= 1'b0; // [R13]
            end
        end
    end

    // stored register bits; the latch and busy positions of the data are dropped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            protectLevel <= sfwp_pkg::LEVEL_RESET; // [R22]
            quadIoEnable <= sfwp_pkg::QUAD_RESET;
            registerLockBit <= sfwp_pkg::LOCK_RESET;
            areaOriginSelect <= sfwp_pkg::ORIGIN_RESET; // [R1]
        end else if (wrDone) begin
            protectLevel <= pendStatus[sfwp_pkg::SR_LEVEL_HI:sfwp_pkg::SR_LEVEL_LO]; // [R6] [R8]
            quadIoEnable <= pendStatus[sfwp_pkg::SR_QUAD]; // [R6]
            registerLockBit <= pendStatus[sfwp_pkg::SR_LOCK]; // [R6]
            if (pendTwo) begin
                areaOriginSelect <= areaOriginSelect | pendConfig[sfwp_pkg::CR_ORIGIN]; // [R2] [R24]
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            writeLatch <= 1'b0;
            busyFlag <= 1'b0;
            hardLockMode <= 1'b0;
            eraseProgramGo <= 1'b0;
            eraseProgramRefused <= 1'b0;
        end else begin
            writeLatch <= next_writeLatch; // [R8] [R21]
            busyFlag <= wrStart || (wrBusy && !wrDone) || arrayBusy; // [R13]
            hardLockMode <= hardLockNow; // [R17]
            eraseProgramGo <= peGrant; // [R19]
            eraseProgramRefused <= peRefuse; // [R19]
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_ORIGIN_STICKY: assert property ($past(areaOriginSelect) |-> areaOriginSelect) // [R24]
        else $error("orientation bit fell back to 0");
    AST_ORIGIN_ONLY_BY_WRITE: assert property ($changed(areaOriginSelect) |-> $past(wrDone && pendTwo)) // [R2]
        else $error("orientation bit changed outside a register write");
    AST_START_LENGTH: assert property (wrStart |-> lenValid && csRise) // [R11]
        else $error("write cycle started on a bad frame length");
    AST_NO_START_LOCKED: assert property (wrStart |-> !hardLockNow && writeLatch) // [R9] [R16]
        else $error("write cycle started while hardware locked");
    AST_BUSY_THROUGH: assert property (wrStart |=> busyFlag ##1 busyFlag) // [R12] [R13]
        else $error("busy flag not set after write start");
    AST_END_CLEARS: assert property (wrDone && !arrayBusy |=> !busyFlag && !writeLatch && !wrBusy) // [R13]
        else $error("busy or latch not cleared at write end");
    AST_LATCH_RISE: assert property ($rose(writeLatch) |-> $past(latchSet)) // [R8] [R21]
        else $error("write latch set without its command");
    AST_PROTECTED_REFUSED: assert property (eraseProgramReq && eraseProgramProtected
        |=> !eraseProgramGo && eraseProgramRefused && !writeLatch) // [R19] [R21]
        else $error("protected program or erase not refused");
    AST_HARD_LOCK: assert property (registerLockBit && !wpS && !quadIoEnable |=> hardLockMode) // [R17]
        else $error("hardware lock mode not entered");
    AST_HARD_LOCK_EXIT: assert property (wpS |=> !hardLockMode) // [R18]
        else $error("hardware lock persisted with guard pin high");
    AST_READ_WHILE_BUSY: assert property (opcodeDone && opByte == sfwp_pkg::OP_READ_CONFIG && !csS
        |=> state == sfwp_pkg::ST_READOUT) // [R3]
        else $error("configuration read not accepted");

    COV_WRITE_ONE: cover property (wrStart && bitCnt == sfwp_pkg::BITS_WRITE_ONE);
    COV_WRITE_TWO: cover property (wrStart && bitCnt == sfwp_pkg::BITS_WRITE_TWO);
    COV_READ_BUSY: cover property (opcodeDone && opByte == sfwp_pkg::OP_READ_CONFIG && wrBusy);
    COV_LOCKED_REJECT: cover property (argsEnd && cmdOp == sfwp_pkg::OP_WRITE_REGISTERS && lenValid
        && writeLatch && hardLockNow);

endmodule : sfwp_core

// file: verification/sfwp_host.sv
// host serial controller model that frames commands towards the block
module sfwp_host (
    input wire logic clk,
    output logic chipSelectN,
    output logic serialClock,
    output logic serialIn,
    input wire logic serialOut
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        chipSelectN = 1'b1;
        serialClock = 1'b0;
        serialIn = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt

    // mode 0 frame: opcode, data msb first, then read bits; clock idles low
    task automatic frame(input logic [7:0] op, input logic [15:0] d, input int nd, input int nr,
                         output logic [7:0] r);
        logic [23:0] sh;
        sh = {op, d};
        r = 8'h00;
        wt(1);
        chipSelectN = 1'b0;
        wt(4);
        for (int i = 0; i < 8 + nd + nr; i++) begin
            serialClock = 1'b0;
            serialIn = (i < 8 + nd) ? sh[23 - i] : ~serialIn;
            wt(4);
            serialClock = 1'b1;
            if (i >= 8 + nd) begin
                r = {r[6:0], serialOut};
            end
            wt(4);
        end
        serialClock = 1'b0;
        wt(4);
        chipSelectN = 1'b1;
        // released line must not keep the last bit
        serialIn = ~serialIn;
        wt(4);
    endtask : frame
endmodule : sfwp_host

// file: verification/tb.sv
// self-checking bench of the register write-protect block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WC = 200;
    typedef struct {string nm; logic [7:0] v;} sfwp_note_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic writeGuardPinN = 1'b1;
    logic arrayBusy = 1'b0;
    logic eraseProgramReq = 1'b0;
    logic eraseProgramProtected = 1'b0;
    logic eraseProgramDone = 1'b0;
    logic chipSelectN, serialClock, serialIn, serialOut, serialOutEn, eraseProgramGo, eraseProgramRefused;
    logic areaOriginSelect, quadIoEnable, registerLockBit, writeLatch, busyFlag, hardLockMode;
    logic [3:0] protectLevel;
    logic [31:0] lfsrState = 32'h00010BD5;
    logic [7:0] seenV;
    sfwp_note_t notes[$];
    event resEv;
    int n_mismatch = 0;
    int cmp_count = 0;
    int busyRun = 0;
    int lastRun = 0;

    always #50 clk = ~clk;

    // length of the last busy stretch in clock edges
    always @(posedge clk) begin
        if (busyFlag === 1'b1) begin
            busyRun <= busyRun + 1;
        end else if (busyRun != 0) begin
            lastRun <= busyRun;
            busyRun <= 0;
        end
    end

    sfwp_core #(.WRITE_CYCLES(WC)) dut (
        .clk(clk), .rstn(rstn), .chipSelectN(chipSelectN), .serialClock(serialClock), .serialIn(serialIn),
        .writeGuardPinN(writeGuardPinN), .arrayBusy(arrayBusy), .eraseProgramReq(eraseProgramReq),
        .eraseProgramProtected(eraseProgramProtected), .eraseProgramDone(eraseProgramDone),
        .serialOut(serialOut), .serialOutEn(serialOutEn), .eraseProgramGo(eraseProgramGo),
        .eraseProgramRefused(eraseProgramRefused), .protectLevel(protectLevel),
        .areaOriginSelect(areaOriginSelect), .quadIoEnable(quadIoEnable), .registerLockBit(registerLockBit),
        .writeLatch(writeLatch), .busyFlag(busyFlag), .hardLockMode(hardLockMode)
    );
    sfwp_host host (.clk(clk), .chipSelectN(chipSelectN), .serialClock(serialClock), .serialIn(serialIn),
        .serialOut(serialOut));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic cmp(input string nm, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : cmp

    // watcher pairs each appearing result with the oldest note
    always @(resEv) begin
        sfwp_note_t n;
        n = notes.pop_front();
        cmp(n.nm, seenV, n.v);
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        notes.push_back('{nm, e});
        seenV = s;
        ->resEv;
        @(negedge clk);
    endtask : chk

    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        host.frame(op, 16'h0000, 0, 0, r);
    endtask : cmd

    task automatic wr(input logic [15:0] d, input int nd);
        logic [7:0] r;
        host.frame(sfwp_pkg::OP_WRITE_REGISTERS, d, nd, 0, r);
    endtask : wr

    task automatic chkReg(input logic [7:0] op, input logic [7:0] e);
        logic [7:0] r;
        host.frame(op, 16'h0000, 0, 8, r);
        chk(op == sfwp_pkg::OP_READ_CONFIG ? "config" : "status", e, r);
    endtask : chkReg

    // counts busy cycles of one write; a register read may run beside it in a fork
    task automatic waitWrite();
        int n;
        n = 0;
        for (int i = 0; i < 20 && busyFlag !== 1'b1; i++) @(negedge clk);
        for (int i = 0; i < 2 * WC && busyFlag === 1'b1; i++) begin
            n++;
            @(negedge clk);
        end
        if (n == 0 || busyFlag !== 1'b0) begin
            n_mismatch++;
            conclude();
        end
        @(negedge clk);
        chk("busyCycles", WC[7:0], lastRun[7:0]);
        chk("latchAfter", 8'h00, {7'h00, writeLatch});
    endtask : waitWrite

    task automatic ep(input logic prot, input logic [1:0] e);
        logic [1:0] s;
        s = 2'b00;
        eraseProgramReq = 1'b1;
        eraseProgramProtected = prot;
        repeat (2) begin
            @(negedge clk);
            eraseProgramReq = 1'b0;
            s = s | {eraseProgramGo, eraseProgramRefused};
        end
        chk("grant", {6'h00, e}, {6'h00, s});
    endtask : ep

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        #5ms;
        n_mismatch++;
        conclude();
    end

    initial begin
        logic [7:0] d;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        chkReg(sfwp_pkg::OP_READ_STATUS, 8'h00);
        chkReg(sfwp_pkg::OP_READ_CONFIG, 8'h00);
        $display("test reset values done");
        cmd(sfwp_pkg::OP_WRITE_LATCH_SET);
        wr(16'hFF00, 4);
        repeat (10) @(negedge clk);
        chk("busyShort", 8'h00, {7'h00, busyFlag});
        chkReg(sfwp_pkg::OP_READ_STATUS, 8'h02);
        cmd(sfwp_pkg::OP_WRITE_LATCH_CLR);
        chk("latchClr", 8'h00, {7'h00, writeLatch});
        $display("test frame length done");
        lfsrState = lfsr(lfsr(lfsrState));
        d = lfsrState[7:0] & 8'h3F;
        cmd(sfwp_pkg::OP_WRITE_LATCH_SET);
        wr({d, 8'h00}, 8);
        fork
            waitWrite();
            chkReg(sfwp_pkg::OP_READ_STATUS, 8'h03);
        join
        chkReg(sfwp_pkg::OP_READ_STATUS, d & 8'h3C);
        chk("level", {4'h0, d[5:2]}, {4'h0, protectLevel});
        $display("test status write done");
        cmd(sfwp_pkg::OP_WRITE_LATCH_SET);
        wr(16'h0008, 16);
        waitWrite();
        chkReg(sfwp_pkg::OP_READ_CONFIG, 8'h08);
        chk("origin", 8'h01, {7'h00, areaOriginSelect});
        cmd(sfwp_pkg::OP_WRITE_LATCH_SET);
        wr(16'h8400, 16);
        fork
            waitWrite();
            chkReg(sfwp_pkg::OP_READ_CONFIG, 8'h08);
        join
        chkReg(sfwp_pkg::OP_READ_STATUS, 8'h84);
        chkReg(sfwp_pkg::OP_READ_CONFIG, 8'h08);
        $display("test two byte write done");
        writeGuardPinN = 1'b0;
        repeat (5) @(negedge clk);
        chk("hardLock", 8'h01, {7'h00, hardLockMode});
        cmd(sfwp_pkg::OP_WRITE_LATCH_SET);
        wr(16'h0000, 8);
        repeat (10) @(negedge clk);
        chk("busyLocked", 8'h00, {7'h00, busyFlag});
        chkReg(sfwp_pkg::OP_READ_STATUS, 8'h86);
        // pin stays high from here through the write cycle
        writeGuardPinN = 1'b1;
        repeat (5) @(negedge clk);
        chk("hardLockOff", 8'h00, {7'h00, hardLockMode});
        wr(16'h0000, 8);
        waitWrite();
        chkReg(sfwp_pkg::OP_READ_STATUS, 8'h00);
        chkReg(sfwp_pkg::OP_READ_CONFIG, 8'h08);
        $display("test protection modes done");
        cmd(sfwp_pkg::OP_WRITE_LATCH_SET);
        ep(1'b1, 2'b01);
        chk("latchRefused", 8'h00, {7'h00, writeLatch});
        ep(1'b0, 2'b00);
        cmd(sfwp_pkg::OP_WRITE_LATCH_SET);
        ep(1'b0, 2'b10);
        eraseProgramDone = 1'b1;
        @(negedge clk);
        eraseProgramDone = 1'b0;
        repeat (2) @(negedge clk);
        chk("latchDone", 8'h00, {7'h00, writeLatch});
        arrayBusy = 1'b1;
        repeat (3) @(negedge clk);
        chk("arrayBusy", 8'h01, {7'h00, busyFlag});
        arrayBusy = 1'b0;
        $display("test program erase side done");
        conclude();
    end
endmodule : tb
